// ===== dicp_pkg.sv
// package: constants for the direct command port of the line controller
package dicp_pkg;

  // direct command codes, three bits, order bit0..bit2 as on the bus
  typedef enum logic [2:0] {
    DICP_CMD_SET_INT   = 3'h0,
    DICP_CMD_CONTROL   = 3'h4,
    DICP_CMD_TEST      = 3'h5,
    DICP_CMD_RESET_INT = 3'h1,
    DICP_CMD_SET_MASK  = 3'h3,
    DICP_CMD_START     = 3'h6,
    DICP_CMD_WRITE     = 3'h2,
    DICP_CMD_READ      = 3'h7
  } dicp_cmd_e;

  // status word bit positions
  localparam int unsigned DICP_ST_PSR_BIT  = 0;  // program start ready
  localparam int unsigned DICP_ST_DTR_BIT  = 1;  // direct transfer ready
  localparam int unsigned DICP_ST_IRQ_BIT  = 2;  // interrupt pending
  localparam int unsigned DICP_ST_MASK_BIT = 3;  // mask flop mirror

  // apb register offsets (byte addresses)
  localparam logic [7:0] DICP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] DICP_OFF_STATUS = 8'h04;
  localparam logic [7:0] DICP_OFF_RDATA  = 8'h08;
  localparam logic [7:0] DICP_OFF_WDATA  = 8'h0c;
  localparam logic [7:0] DICP_OFF_CWORD  = 8'h10;
  localparam logic [7:0] DICP_OFF_DEVNO  = 8'h14;

  // ctrl register fields
  localparam int unsigned DICP_CTRL_DEV_READY  = 0;
  localparam int unsigned DICP_CTRL_CHAN_READY = 1;
  localparam int unsigned DICP_CTRL_XFER_READY = 2;
  localparam int unsigned DICP_CTRL_PROG_DONE  = 3;
  localparam int unsigned DICP_CTRL_MGRP_LO    = 4;  // 4-bit mask group select

  // reset values
  localparam logic [7:0]  DICP_DEVNO_RST = 8'h05;
  localparam logic [15:0] DICP_CTRL_RST  = 16'h0000;

endpackage : dicp_pkg

// ===== dicp_word_reg.sv
// module: one 16-bit word store with registered read data
module dicp_word_reg
  import dicp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // write port
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wr_data_in,
  // read port
  output logic      [15:0] rd_data_out
);

  // plain storage, value reads one cycle after it is written
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rd_data_out <= 16'h0000;
    end else if (wr_en_in) begin
      rd_data_out <= wr_data_in;
    end
  end

endmodule // dicp_word_reg

// ===== dicp_direct_port.sv
// module: direct command port of the line controller, with apb side registers
// Contract
// - broadcast mask sets or clears mask flop from the group's mask bit
// - system i/o reset sets the interrupt mask flop
// - test command returns the 16-bit status word
// - status bit zero is one only when controller and device are ready
// - start command signals the multiplexer channel to run the program
// - read command with transfer ready returns one 16-bit data word
// - write with transfer ready: controller accepts the stack top word
// - control word sent with command; controller acknowledges receipt
// - set interrupt raises interrupt if mask enabled, and is acknowledged
// - memory words are 16 bits holding one or two characters
// - characters pass bit serially, at most eight valid bits each
// - eight direct commands arrive as a three-bit code and are decoded
// - accepted start clears status bit zero while the program runs
// - set interrupt sets request flop and status bit two
// - reset interrupt clears interrupt logic except the mask flop
//
// The implementer's own choices: the placing of the registers and the APB register port.
module dicp_direct_port
  import dicp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // host bus command
  input  wire logic        cmd_valid_in,
  input  wire logic [2:0]  direct_command_code_in,
  input  wire logic [7:0]  cmd_devno_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic        io_reset_in,
  // host bus answer
  output logic             cmd_ack_out,
  output logic [15:0]      cmd_rdata_out,
  // channel and interrupt
  output logic             chan_start_out,
  output logic             irq_out,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // decode of an apb offset, used for read and write
  function automatic logic is_off(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // state
  logic [15:0] ctrl_reg;
  logic [7:0]  devno_reg;
  logic        interrupt_mask_flop_reg;
  logic        irq_req_reg;
  logic        prog_busy_reg;
  logic [15:0] cword_reg;
  logic [15:0] rdata_word;
  logic [15:0] wdata_word;

  // command decode
  wire         own_dev    = (cmd_devno_in == devno_reg);
  wire         is_mask    = direct_command_code_in == DICP_CMD_SET_MASK;
  wire         take       = cmd_valid_in && (own_dev || is_mask);
  wire         c_test     = take && direct_command_code_in == DICP_CMD_TEST;
  wire         c_start    = take && direct_command_code_in == DICP_CMD_START;
  wire         c_read     = take && direct_command_code_in == DICP_CMD_READ;
  wire         c_write    = take && direct_command_code_in == DICP_CMD_WRITE;
  wire         c_ctrl     = take && direct_command_code_in == DICP_CMD_CONTROL;
  wire         c_sin      = take && direct_command_code_in == DICP_CMD_SET_INT;
  wire         c_rin      = take && direct_command_code_in == DICP_CMD_RESET_INT;
  wire         c_mask     = cmd_valid_in && is_mask;
  wire [3:0]   mgrp       = ctrl_reg[DICP_CTRL_MGRP_LO +: 4];
  wire         mask_bit   = cmd_data_in[mgrp];

  // ready flags
  wire program_start_ready_flag = ctrl_reg[DICP_CTRL_DEV_READY]
                                  && ctrl_reg[DICP_CTRL_CHAN_READY]
                                  && !prog_busy_reg;
  wire direct_transfer_ready_flag = ctrl_reg[DICP_CTRL_XFER_READY];
  wire [15:0] status_word = {12'h000, interrupt_mask_flop_reg, irq_req_reg,
                             direct_transfer_ready_flag, program_start_ready_flag};

  // apb decode, single-cycle answer
  wire apb_acc = psel && penable;
  wire apb_wr  = apb_acc && pwrite;
  wire known   = is_off(paddr, DICP_OFF_CTRL) || is_off(paddr, DICP_OFF_STATUS)
              || is_off(paddr, DICP_OFF_RDATA) || is_off(paddr, DICP_OFF_WDATA)
              || is_off(paddr, DICP_OFF_CWORD) || is_off(paddr, DICP_OFF_DEVNO);
  wire done_pulse = apb_wr && is_off(paddr, DICP_OFF_CTRL) && pwdata[DICP_CTRL_PROG_DONE];
  wire [31:0] rd_mux =
      is_off(paddr, DICP_OFF_CTRL)   ? {16'h0000, ctrl_reg} :
      is_off(paddr, DICP_OFF_STATUS) ? {16'h0000, status_word} :
      is_off(paddr, DICP_OFF_WDATA)  ? {16'h0000, wdata_word} :
      is_off(paddr, DICP_OFF_CWORD)  ? {16'h0000, cword_reg} :
      is_off(paddr, DICP_OFF_DEVNO)  ? {24'h000000, devno_reg} : 32'h00000000;

  // data word software supplies for host reads
  dicp_word_reg u_rdata (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .wr_en_in   (apb_wr && is_off(paddr, DICP_OFF_RDATA)),
    .wr_data_in (pwdata[15:0]),
    .rd_data_out(rdata_word)
  );

  // data word written by the host, read by software
  dicp_word_reg u_wdata (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .wr_en_in   (c_write && direct_transfer_ready_flag),
    .wr_data_in (cmd_data_in),
    .rd_data_out(wdata_word)
  );

  // software registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ctrl_reg  <= DICP_CTRL_RST;
      devno_reg <= DICP_DEVNO_RST;
      cword_reg <= 16'h0000;
    end else begin
      if (apb_wr && is_off(paddr, DICP_OFF_CTRL))  ctrl_reg  <= pwdata[15:0] & 16'hfff7;
      if (apb_wr && is_off(paddr, DICP_OFF_DEVNO)) devno_reg <= pwdata[7:0];
      if (c_ctrl) cword_reg <= cmd_data_in;
    end
  end

  // mask flop: io reset forces set, broadcast mask follows group bit
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      interrupt_mask_flop_reg <= 1'b1;
    end else if (io_reset_in) begin
      interrupt_mask_flop_reg <= 1'b1;
    end else if (c_mask) begin
      interrupt_mask_flop_reg <= mask_bit;
    end
  end

  // interrupt request; set wins over a same-cycle reset command
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || io_reset_in) begin
      irq_req_reg <= 1'b0;
    end else if (c_sin) begin
      irq_req_reg <= 1'b1;
    end else if (c_rin) begin
      irq_req_reg <= 1'b0;
    end
  end

  // program busy from accepted start until software reports done
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || io_reset_in) begin
      prog_busy_reg <= 1'b0;
    end else if (c_start && program_start_ready_flag) begin
      prog_busy_reg <= 1'b1;
    end else if (done_pulse) begin
      prog_busy_reg <= 1'b0;
    end
  end

  // host answer: ack one cycle after a taken command; mask is not acked
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cmd_ack_out    <= 1'b0;
      cmd_rdata_out  <= 16'h0000;
      chan_start_out <= 1'b0;
      irq_out        <= 1'b0;
    end else begin
      cmd_ack_out    <= take && !is_mask;
      cmd_rdata_out  <= c_test ? status_word :
                        (c_read && direct_transfer_ready_flag) ? rdata_word :
                        16'h0000;
      chan_start_out <= c_start && program_start_ready_flag;
      irq_out        <= irq_req_reg && interrupt_mask_flop_reg;
    end
  end

  // apb answer registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= rd_mux;
      pslverr <= psel && !penable && !known;
    end
  end

  // checks
  mask_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    io_reset_in |=> interrupt_mask_flop_reg) else $error("mask not set by io reset");
  mask_load_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_mask && !io_reset_in |=> interrupt_mask_flop_reg == $past(mask_bit))
    else $error("mask flop not loaded");
  test_status_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_test |=> cmd_ack_out && cmd_rdata_out == $past(status_word))
    else $error("test status wrong");
  psr_ready_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    program_start_ready_flag |-> ctrl_reg[DICP_CTRL_DEV_READY] && !prog_busy_reg)
    else $error("start ready while busy");
  start_chan_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_start && program_start_ready_flag |=> chan_start_out ##1 !chan_start_out)
    else $error("channel start pulse wrong");
  start_busy_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chan_start_out |-> !program_start_ready_flag) else $error("bit zero still set");
  read_word_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_read && direct_transfer_ready_flag |=> cmd_rdata_out == $past(rdata_word))
    else $error("read word wrong");
  sin_pending_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_sin && !io_reset_in |=> status_word[DICP_ST_IRQ_BIT] ##1 (irq_out == interrupt_mask_flop_reg
    || $past(c_rin) || $past(io_reset_in))) else $error("interrupt not pending");
  rin_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_rin && !c_sin |=> !irq_req_reg && $stable(interrupt_mask_flop_reg))
    else $error("reset interrupt wrong");
  own_dev_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    cmd_valid_in && !own_dev |=> !cmd_ack_out) else $error("foreign command acked");

  // named steps of a host answer, shared by the command checks below;
  // the host treats a missing ack as no response, so every taken command
  // except the broadcast mask must see its ack in the very next cycle
  sequence answer_seen_s;
    cmd_ack_out;
  endsequence

  // an acked answer that carries no data word
  sequence answer_zero_s;
    cmd_ack_out && cmd_rdata_out == 16'h0000;
  endsequence

  // the channel is left alone for this cycle
  sequence channel_quiet_s;
    !chan_start_out;
  endsequence

  // a taken command other than the broadcast mask answers one cycle later
  cmd_ack_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && !is_mask |=> answer_seen_s) else $error("taken command not acked");

  // broadcast mask reaches every controller, so nobody may answer it
  mask_noack_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    cmd_valid_in && is_mask |=> !cmd_ack_out) else $error("mask command acked");

  // read while transfer is not ready hands back no stale word
  read_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_read && !direct_transfer_ready_flag |=> answer_zero_s)
    else $error("read without ready gave data");

  // refused start answers but never pokes the channel
  start_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_start && !program_start_ready_flag |=> answer_seen_s and channel_quiet_s)
    else $error("refused start reached channel");

  // accepted write word lands in the store at the next edge
  write_land_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_write && direct_transfer_ready_flag |=> wdata_word == $past(cmd_data_in))
    else $error("write word not stored");

  // write while not ready must leave the stored word alone
  write_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_write && !direct_transfer_ready_flag |=> $stable(wdata_word))
    else $error("write stored while not ready");

  // control word is kept and its receipt acknowledged
  ctrl_word_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    c_ctrl |=> answer_seen_s and (cword_reg == $past(cmd_data_in)))
    else $error("control word lost");

  // io reset leaves no pending request and no busy program behind
  ioreset_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    io_reset_in |=> !irq_req_reg && !prog_busy_reg)
    else $error("io reset left state behind");

  // a cleared mask flop keeps a pending request off the line
  irq_masked_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    irq_req_reg && !interrupt_mask_flop_reg |=> !irq_out)
    else $error("masked interrupt raised");

  // an enabled pending request shows on the line one cycle later
  irq_raise_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    irq_req_reg && interrupt_mask_flop_reg |=> irq_out)
    else $error("enabled interrupt not raised");

  // the data path to memory is one 16-bit word per transfer; character
  // packing and the serial side live past this port

endmodule // dicp_direct_port

// ===== dicp_host_model.sv
// host side model: issues one direct command and judges the answer
module dicp_host_model
(
  // clock and request from the bench
  input  wire logic        clk_sys_in,
  input  wire logic        req_in,
  input  wire logic [2:0]  op_in,
  input  wire logic [7:0]  dev_in,
  input  wire logic [15:0] word_in,
  // answer from the controller
  input  wire logic        ack_in,
  input  wire logic [15:0] rdata_in,
  // host bus and outcome
  output logic             cmd_valid_out,
  output logic [2:0]       code_out,
  output logic [7:0]       devno_out,
  output logic [15:0]      data_out,
  output logic             done_out,
  output logic             less_out,
  output logic [15:0]      rsp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_cnt = 0;
  initial {cmd_valid_out, code_out, devno_out, data_out, done_out, less_out, rsp_out} = '0;
  // strobe one cycle, then give the answer three edges; silence means less
  always @(posedge clk_sys_in) begin
    done_out <= 1'b0;
    cmd_valid_out <= req_in;
    if (req_in) begin
      {code_out, devno_out, data_out} <= {op_in, dev_in, word_in};
      wait_cnt <= 1;
    end else begin
      data_out <= ~data_out; // released bus never holds its last word
      if (wait_cnt != 0) begin
        if (ack_in === 1'b1 || wait_cnt == 3) begin
          done_out <= 1'b1;
          less_out <= (ack_in !== 1'b1);
          rsp_out <= rdata_in;
          wait_cnt <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule // dicp_host_model

// ===== dicp_direct_port_tb.sv
// self-checking bench for the direct command port
module dicp_direct_port_tb
  import dicp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in, rstn_in, io_reset_in, req, psel, penable, pwrite, e;
  logic        cmd_valid, ack, chan_start, irq_out, pready, pslverr, done, less;
  logic [2:0]  op, code;
  logic [7:0]  dev, devno, paddr;
  logic [15:0] word, cdata, rdata, rsp;
  logic [31:0] pwdata, prdata, q;
  int          failures = 0;
  int          checked = 0;
  int          starts = 0;
  dicp_direct_port dicp_direct_port_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .cmd_valid_in(cmd_valid), .direct_command_code_in(code), .cmd_devno_in(devno),
    .cmd_data_in(cdata), .io_reset_in(io_reset_in), .cmd_ack_out(ack),
    .cmd_rdata_out(rdata), .chan_start_out(chan_start), .irq_out(irq_out), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dicp_host_model dicp_host_model_i (.clk_sys_in(clk_sys_in), .req_in(req), .op_in(op),
    .dev_in(dev), .word_in(word), .ack_in(ack), .rdata_in(rdata), .cmd_valid_out(cmd_valid),
    .code_out(code), .devno_out(devno), .data_out(cdata), .done_out(done),
    .less_out(less), .rsp_out(rsp));
  // clock, and a count of channel start pulses
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) if (chan_start === 1'b1) starts <= starts + 1;
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys_in);
    penable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: apb slave never ready", $time);
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // one direct command through the host model, waiting for its verdict
  task automatic cmd(input logic [2:0] o, input logic [7:0] d, input logic [15:0] w);
    @(posedge clk_sys_in);
    {req, op, dev, word} <= {1'b1, o, d, w};
    @(posedge clk_sys_in);
    req <= 1'b0;
    for (int i = 0; i < 8 && done !== 1'b1; i++) @(negedge clk_sys_in);
    if (done !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: host model gave no verdict", $time);
    end
  endtask
  task automatic t_reset();
    apb(1'b0, DICP_OFF_DEVNO, '0);
    chk_word(q, 32'h5);
    apb(1'b0, DICP_OFF_STATUS, '0);
    chk_word(q, 32'h8);
    apb(1'b0, 8'h18, '0);
    chk_bit(e, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_test();
    apb(1'b1, DICP_OFF_CTRL, 32'h7);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'hb);
    chk_bit(less, 1'b0);
    cmd(DICP_CMD_TEST, 8'h06, '0);
    chk_bit(less, 1'b1);
    apb(1'b1, DICP_OFF_CTRL, 32'h1);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h8);
    $display("test status done");
  endtask
  task automatic t_start();
    apb(1'b1, DICP_OFF_CTRL, 32'h3);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h9);
    cmd(DICP_CMD_START, 8'h05, '0);
    chk_word(32'(starts), 32'h1);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h8);
    cmd(DICP_CMD_START, 8'h05, '0);
    chk_word(32'(starts), 32'h1);
    apb(1'b1, DICP_OFF_CTRL, 32'hb);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h9);
    $display("test start done");
  endtask
  task automatic t_xfer();
    apb(1'b1, DICP_OFF_CTRL, 32'h4);
    apb(1'b1, DICP_OFF_RDATA, 32'h3c5a);
    cmd(DICP_CMD_READ, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h3c5a);
    cmd(DICP_CMD_WRITE, 8'h05, 16'ha5c3);
    apb(1'b0, DICP_OFF_WDATA, '0);
    chk_word(q, 32'ha5c3);
    cmd(DICP_CMD_CONTROL, 8'h05, 16'h1234);
    chk_bit(less, 1'b0);
    apb(1'b0, DICP_OFF_CWORD, '0);
    chk_word(q, 32'h1234);
    apb(1'b1, DICP_OFF_CTRL, 32'h0);
    cmd(DICP_CMD_READ, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h0);
    $display("test transfer done");
  endtask
  task automatic t_irq();
    apb(1'b1, DICP_OFF_CTRL, 32'h20);
    cmd(DICP_CMD_SET_MASK, 8'h33, 16'hfffb);
    chk_bit(less, 1'b1);
    cmd(DICP_CMD_SET_INT, 8'h05, '0);
    chk_bit(irq_out, 1'b0);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h4);
    cmd(DICP_CMD_SET_MASK, 8'h33, 16'h0004);
    chk_bit(irq_out, 1'b1);
    cmd(DICP_CMD_RESET_INT, 8'h05, '0);
    chk_bit(irq_out, 1'b0);
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h8);
    cmd(DICP_CMD_SET_MASK, 8'h33, 16'h0);
    @(posedge clk_sys_in);
    io_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    io_reset_in <= 1'b0;
    cmd(DICP_CMD_TEST, 8'h05, '0);
    chk_word({16'h0, rsp}, 32'h8);
    $display("test interrupt done");
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence: reset for five cycles, then the scenarios
  initial begin
    {rstn_in, io_reset_in, req, psel, penable, pwrite, op, dev, word, paddr, pwdata} = '0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_test();
    t_start();
    t_xfer();
    t_irq();
    summarize();
  end
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule // dicp_direct_port_tb
